/* File: design/mis_pkg.sv */
// constants and types shared by the maskable interrupt sequencer
package mis_pkg;
    // ------------------------------------------------------------
    // interrupt lines
    // ------------------------------------------------------------
    localparam int NUM_LINES = 16;
    localparam int NUM_GEN = 14;
    localparam int BIT_DLOG = 14;
    localparam int BIT_OS = 15;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PEND_OR = 8'h00;
    localparam logic [7:0] OFS_PEND_AND = 8'h04;
    localparam logic [7:0] OFS_ENABLE = 8'h08;
    localparam logic [7:0] OFS_STAT1 = 8'h0C;
    localparam logic [7:0] OFS_SP = 8'h10;
    localparam logic [7:0] OFS_STATE = 8'h14;
    localparam logic [7:0] OFS_ACK = 8'h18;
    localparam logic [7:0] OFS_RETURN = 8'h1C;

    // ------------------------------------------------------------
    // status_one bit positions
    // ------------------------------------------------------------
    localparam int S1_GMASK = 0;
    localparam int S1_DEBUG_EVENT_MASK = 1;
    localparam int S1_LOOP = 4;
    localparam int S1_PWE = 6;
    localparam int S1_IDLE = 7;

    // ------------------------------------------------------------
    // reset values and step counts
    // ------------------------------------------------------------
    localparam logic [15:0] RST_PEND = 16'h0000;
    localparam logic [15:0] RST_ENABLE = 16'h0000;
    localparam logic [15:0] RST_STAT1 = 16'h0003;
    localparam logic [15:0] RST_SP = 16'h0400;
    localparam logic [2:0] SAVE_PAIRS = 3'h7;
    localparam logic [2:0] PAIR_ENABLE = 3'h5;
    localparam logic [15:0] SP_FIRST_STEP = 16'h0001;
    localparam logic [15:0] SP_PAIR_STEP = 16'h0002;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE, ST_DRAIN, ST_VEC_REQ, ST_VEC_WAIT, ST_VEC_TAKE, ST_SP_BUMP,
        ST_SAVE, ST_STATUS, ST_JUMP, ST_R_DEC, ST_R_WAIT, ST_R_TAKE, ST_R_END
    } mis_state_t;
endpackage

/* File: design/mis_sync2.sv */
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
`default_nettype none
module mis_sync2 #(
    parameter int W = 14,
    parameter logic [W-1:0] INIT = '1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // levels
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_reg <= INIT;
            sync_o <= INIT;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule // mis_sync2
`default_nettype wire

/* File: design/mis_prio_pick.sv */
// fixed priority pick: lowest bit index wins
`timescale 1ns/1ns
`default_nettype none
module mis_prio_pick #(
    parameter int N = 16
) (
    // candidates
    input wire logic [N-1:0] req_i,
    // winner
    output logic valid_o,
    output logic [$clog2(N)-1:0] idx_o
);
    // scan from the top so the lowest set bit is kept last
    always_comb begin
        valid_o = 1'b0;
        idx_o = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                valid_o = 1'b1;
                idx_o = i[$clog2(N)-1:0];
            end
        end
    end
endmodule // mis_prio_pick
`default_nettype wire

/* File: design/mis_sequencer.sv */
// maskable interrupt sequencer: pending flags, approval, entry and return
`timescale 1ns/1ns
`default_nettype none
module mis_sequencer
    import mis_pkg::*;
#(
    parameter int PCW = 22,
    parameter logic [PCW-1:0] VEC_BASE = 22'h00_0D00
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    // request sources
    input wire logic [NUM_GEN-1:0] general_irq_lines_n_i,
    input wire logic data_logging_irq_i,
    input wire logic os_service_irq_i,
    // core context
    input wire logic [PCW-1:0] pc_i,
    input wire logic instr_len2_i,
    input wire logic [15:0] status_zero_i,
    input wire logic [15:0] temp_i,
    input wire logic [15:0] acc_low_i,
    input wire logic [15:0] acc_high_i,
    input wire logic [15:0] product_low_i,
    input wire logic [15:0] product_high_i,
    input wire logic [15:0] aux_zero_i,
    input wire logic [15:0] aux_one_i,
    input wire logic [15:0] data_page_ptr_i,
    input wire logic [15:0] debug_status_word_i,
    // pipeline control
    input wire logic drain_done_i,
    output logic flush_o,
    output logic pc_load_o,
    output logic [PCW-1:0] pc_value_o,
    // program read path
    output logic prog_rd_o,
    output logic [PCW-1:0] prog_addr_o,
    input wire logic [31:0] prog_data_i,
    // stack and data write bus
    output logic stk_we_o,
    output logic stk_re_o,
    output logic [15:0] stk_addr_o,
    output logic [31:0] data_write_bus_o,
    input wire logic [31:0] stk_rdata_i,
    output logic ack_o,
    // restored context
    output logic restore_valid_o,
    output logic [2:0] restore_sel_o,
    output logic [31:0] restore_data_o,
    // status
    output logic [15:0] status_one_o
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    mis_state_t state_reg;
    logic [15:0] pend_reg;
    logic [15:0] enable_reg;
    logic [15:0] stat1_reg;
    logic [15:0] sp_reg;
    logic [PCW-1:0] ret_addr_reg;
    logic [PCW-1:0] vector_reg;
    logic [3:0] cur_idx_reg;
    logic [2:0] pair_reg;
    logic [NUM_GEN-1:0] lines_n_sync;
    logic [15:0] hw_req;
    logic [15:0] sw_set;
    logic [15:0] sw_clr;
    logic [15:0] appr_clr;
    logic [15:0] pick_req;
    logic pick_valid;
    logic [3:0] pick_idx;
    logic approve;
    logic wr_pend_and;
    logic wr_enable;
    logic wr_stat1;
    logic wr_sp;
    logic [15:0] enable_clr;
    logic [31:0] save_word;

    // ------------------------------------------------------------
    // request sources
    // ------------------------------------------------------------
    // general lines come from pins: two flops first
    mis_sync2 #(
        .W(NUM_GEN),
        .INIT({NUM_GEN{1'b1}})
    ) u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(general_irq_lines_n_i),
        .sync_o(lines_n_sync)
    );

    // line x to bit x-1, logging and os on top bits
    assign hw_req = {os_service_irq_i, data_logging_irq_i, ~lines_n_sync};

    // software writes to the flag, enable, status one and stack pointer registers
    assign sw_set = (reg_we_i && reg_addr_i == OFS_PEND_OR) ? reg_wdata_i[15:0] : 16'h0000;
    assign wr_pend_and = reg_we_i && reg_addr_i == OFS_PEND_AND;
    assign sw_clr = wr_pend_and ? ~reg_wdata_i[15:0] : 16'h0000;
    assign wr_enable = reg_we_i && reg_addr_i == OFS_ENABLE;
    assign wr_stat1 = reg_we_i && reg_addr_i == OFS_STAT1;
    assign wr_sp = reg_we_i && reg_addr_i == OFS_SP;

    // ------------------------------------------------------------
    // approval
    // ------------------------------------------------------------
    assign pick_req = pend_reg & enable_reg;

    mis_prio_pick #(
        .N(NUM_LINES)
    ) u_pick (
        .req_i(pick_req),
        .valid_o(pick_valid),
        .idx_o(pick_idx)
    );

    // only an idle sequencer with the mask clear approves
    assign approve = (state_reg == ST_IDLE) && pick_valid && !stat1_reg[S1_GMASK];
    assign appr_clr = approve ? (16'h0001 << pick_idx) : 16'h0000;

    // ------------------------------------------------------------
    // pending flags
    // ------------------------------------------------------------
    // new requests win over any clear in the same cycle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pend_reg <= RST_PEND;
        end else begin
            pend_reg <= (pend_reg & ~sw_clr & ~appr_clr) | hw_req | sw_set;
        end
    end

    // ------------------------------------------------------------
    // enable register
    // ------------------------------------------------------------
    // served bit drops once its pair is on the stack
    assign enable_clr = (state_reg == ST_SAVE && pair_reg == PAIR_ENABLE + 3'h1)
        ? (16'h0001 << cur_idx_reg) : 16'h0000;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            enable_reg <= RST_ENABLE;
        end else if (wr_enable) begin
            enable_reg <= reg_wdata_i[15:0] & ~enable_clr;
        end else begin
            enable_reg <= enable_reg & ~enable_clr;
        end
    end

    // ------------------------------------------------------------
    // status one
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stat1_reg <= RST_STAT1;
        end else if (state_reg == ST_STATUS) begin
            stat1_reg[S1_GMASK] <= 1'b1;
            stat1_reg[S1_DEBUG_EVENT_MASK] <= 1'b1;
            stat1_reg[S1_LOOP] <= 1'b0;
            stat1_reg[S1_PWE] <= 1'b0;
            stat1_reg[S1_IDLE] <= 1'b0;
        end else if (state_reg == ST_R_TAKE && pair_reg == 3'h5) begin // status pair pops
            stat1_reg <= stk_rdata_i[15:0];
        end else if (wr_stat1) begin
            stat1_reg <= reg_wdata_i[15:0];
        end
    end

    assign status_one_o = stat1_reg;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_IDLE;
            cur_idx_reg <= 4'h0;
            pair_reg <= 3'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (approve) begin
                        cur_idx_reg <= pick_idx;
                        state_reg <= ST_DRAIN;
                    end else if (reg_we_i && reg_addr_i == OFS_RETURN) begin
                        pair_reg <= SAVE_PAIRS;
                        state_reg <= ST_R_DEC;
                    end
                end
                ST_DRAIN: begin
                    if (drain_done_i) begin
                        state_reg <= ST_VEC_REQ;
                    end
                end
                ST_VEC_REQ: state_reg <= ST_VEC_WAIT;
                ST_VEC_WAIT: state_reg <= ST_VEC_TAKE;
                ST_VEC_TAKE: state_reg <= ST_SP_BUMP;
                ST_SP_BUMP: begin
                    pair_reg <= 3'h0;
                    state_reg <= ST_SAVE;
                end
                ST_SAVE: begin
                    if (pair_reg == SAVE_PAIRS - 3'h1) begin
                        state_reg <= ST_STATUS;
                    end
                    pair_reg <= pair_reg + 3'h1;
                end
                ST_STATUS: state_reg <= ST_JUMP;
                ST_JUMP: state_reg <= ST_IDLE;
                ST_R_DEC: state_reg <= ST_R_WAIT;
                ST_R_WAIT: state_reg <= ST_R_TAKE;
                ST_R_TAKE: begin
                    pair_reg <= pair_reg - 3'h1;
                    state_reg <= (pair_reg == 3'h1) ? ST_R_END : ST_R_DEC;
                end
                ST_R_END: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pipeline, return address and vector
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flush_o <= 1'b0;
            ret_addr_reg <= '0;
            vector_reg <= '0;
            prog_rd_o <= 1'b0;
            prog_addr_o <= '0;
        end else begin
            flush_o <= approve;
            prog_rd_o <= (state_reg == ST_VEC_REQ);
            if (state_reg == ST_DRAIN && drain_done_i) begin
                ret_addr_reg <= pc_i + (instr_len2_i ? PCW'(2) : PCW'(1));
            end
            if (state_reg == ST_VEC_REQ) begin
                prog_addr_o <= VEC_BASE + PCW'({cur_idx_reg, 1'b0});
            end
            if (state_reg == ST_VEC_TAKE) begin
                vector_reg <= prog_data_i[PCW-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // context pairs
    // ------------------------------------------------------------
    // first member in the low (even) half
    always_comb begin
        unique case (pair_reg)
            3'h0: save_word = {temp_i, status_zero_i};
            3'h1: save_word = {acc_high_i, acc_low_i};
            3'h2: save_word = {product_high_i, product_low_i};
            3'h3: save_word = {aux_one_i, aux_zero_i};
            3'h4: save_word = {data_page_ptr_i, stat1_reg};
            3'h5: save_word = {debug_status_word_i, enable_reg};
            default: save_word = 32'(ret_addr_reg);
        endcase
    end

    // ------------------------------------------------------------
    // stack pointer and stack accesses
    // ------------------------------------------------------------
    // sp is sent raw; the wrapper forces even alignment
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sp_reg <= RST_SP;
            stk_we_o <= 1'b0;
            stk_re_o <= 1'b0;
            stk_addr_o <= 16'h0000;
        end else begin
            stk_we_o <= (state_reg == ST_SAVE);
            stk_re_o <= (state_reg == ST_R_DEC);
            if (state_reg == ST_SP_BUMP) begin
                sp_reg <= sp_reg + SP_FIRST_STEP;
            end else if (state_reg == ST_SAVE) begin
                stk_addr_o <= sp_reg;
                sp_reg <= sp_reg + SP_PAIR_STEP;
            end else if (state_reg == ST_R_DEC) begin
                stk_addr_o <= sp_reg - SP_PAIR_STEP;
                sp_reg <= sp_reg - SP_PAIR_STEP;
            end else if (state_reg == ST_R_END) begin
                sp_reg <= sp_reg - SP_FIRST_STEP;
            end else if (wr_sp) begin
                sp_reg <= reg_wdata_i[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // data write bus and acknowledge
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            data_write_bus_o <= 32'h0000_0000;
            ack_o <= 1'b0;
        end else begin
            ack_o <= reg_we_i && reg_addr_i == OFS_ACK;
            if (state_reg == ST_SAVE) begin
                data_write_bus_o <= save_word;
            end else if (reg_we_i && reg_addr_i == OFS_ACK) begin
                data_write_bus_o <= {16'h0000, reg_wdata_i[15:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // program counter load and restore
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pc_load_o <= 1'b0;
            pc_value_o <= '0;
            restore_valid_o <= 1'b0;
            restore_sel_o <= 3'h0;
            restore_data_o <= 32'h0000_0000;
        end else begin
            pc_load_o <= (state_reg == ST_JUMP) || (state_reg == ST_R_END);
            restore_valid_o <= (state_reg == ST_R_TAKE);
            // first pop is the return address, held until the final load
            if (state_reg == ST_JUMP) begin
                pc_value_o <= vector_reg;
            end else if (state_reg == ST_R_TAKE && pair_reg == SAVE_PAIRS) begin
                pc_value_o <= stk_rdata_i[PCW-1:0];
            end
            if (state_reg == ST_R_TAKE) begin
                restore_sel_o <= pair_reg - 3'h1;
                restore_data_o <= stk_rdata_i;
            end
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_re_i) begin
            unique case (reg_addr_i)
                OFS_PEND_OR: reg_rdata_o <= {16'h0000, pend_reg};
                OFS_ENABLE: reg_rdata_o <= {16'h0000, enable_reg};
                OFS_STAT1: reg_rdata_o <= {16'h0000, stat1_reg};
                OFS_SP: reg_rdata_o <= {16'h0000, sp_reg};
                OFS_STATE: reg_rdata_o <= {24'h00_0000, state_reg, cur_idx_reg};
                default: reg_rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end
endmodule // mis_sequencer
`default_nettype wire

/* File: bench/mis_seq_asserts.sv */
// port checker for the maskable interrupt sequencer
`timescale 1ns/1ns
`default_nettype none
module mis_seq_asserts
    import mis_pkg::*;
#(
    parameter int PCW = 22
) (
    // watched ports
    input wire logic clk_i, sys_rst_i, reg_we_i, flush_o, pc_load_o, prog_rd_o,
    input wire logic stk_we_o, stk_re_o, ack_o, restore_valid_o,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i, prog_data_i, data_write_bus_o, stk_rdata_i,
    input wire logic [31:0] restore_data_o,
    input wire logic [PCW-1:0] pc_value_o,
    input wire logic [15:0] stk_addr_o, status_one_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // slices kept as nets for the sampled-value functions
    wire logic [PCW-1:0] vec_w = prog_data_i[PCW-1:0];
    wire logic [15:0] ack_w = reg_wdata_i[15:0];
    wire logic gmask_w = status_one_o[S1_GMASK];
    AST_ACK_OUT: assert property (reg_we_i && reg_addr_i == OFS_ACK |=> ack_o
        && data_write_bus_o == {16'h0000, $past(ack_w)}) else $error("ack value wrong");
    AST_FLUSH_MASK: assert property (flush_o |-> !$past(gmask_w))
        else $error("approval while masked");
    AST_NO_REENTRY: assert property (flush_o |=> !flush_o [*8])
        else $error("second approval too soon");
    AST_SEVEN_PAIRS: assert property ($rose(stk_we_o) |-> stk_we_o [*7] ##1 !stk_we_o)
        else $error("pair write count wrong");
    AST_SP_STEP: assert property (stk_we_o && $past(stk_we_o)
        |-> stk_addr_o == $past(stk_addr_o) + 16'h0002) else $error("stack step wrong");
    AST_VEC_JUMP: assert property (prog_rd_o |-> ##12 (pc_load_o
        && pc_value_o == $past(vec_w, 11))) else $error("jump not to fetched vector");
    AST_STATUS_SET: assert property (prog_rd_o |-> ##12 (status_one_o[1:0] == 2'b11
        && status_one_o[7:6] == 2'b00 && !status_one_o[4])) else $error("status bits wrong");
    AST_RESTORE: assert property (stk_re_o |-> ##2 (restore_valid_o
        && restore_data_o == $past(stk_rdata_i))) else $error("restore data wrong");
    // main scenarios
    COV_ENTRY: cover property (flush_o);
    COV_RETURN: cover property (restore_valid_o);
    COV_ACK: cover property (ack_o);
endmodule // mis_seq_asserts
bind mis_sequencer mis_seq_asserts #(.PCW(PCW)) u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_we_i(reg_we_i), .flush_o(flush_o),
    .pc_load_o(pc_load_o), .prog_rd_o(prog_rd_o), .stk_we_o(stk_we_o), .stk_re_o(stk_re_o),
    .ack_o(ack_o), .restore_valid_o(restore_valid_o), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .prog_data_i(prog_data_i), .stk_rdata_i(stk_rdata_i),
    .data_write_bus_o(data_write_bus_o), .restore_data_o(restore_data_o),
    .pc_value_o(pc_value_o), .stk_addr_o(stk_addr_o), .status_one_o(status_one_o)
);
`default_nettype wire

/* File: bench/mis_far_model.sv */
// far side model: core drain handshake, vector memory and stack wrapper
`timescale 1ns/1ns
`default_nettype none
module mis_far_model #(
    parameter logic [21:0] VTAG = 22'h2A_0000
) (
    // clock, reset and pacing
    input wire logic clk_i, sys_rst_i, slow_i,
    // sequencer side
    input wire logic flush_i, prog_rd_i, stk_we_i, stk_re_i,
    input wire logic [21:0] prog_addr_i,
    input wire logic [15:0] stk_addr_i,
    input wire logic [31:0] wdata_i,
    output logic drain_done_o,
    output logic [31:0] prog_data_o, stk_rdata_o
);
    logic [31:0] mem [256];
    logic [2:0] cnt_reg;
    // older instructions finish one or six cycles after the flush
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_reg <= 3'h0;
            drain_done_o <= 1'b0;
        end else if (flush_i) begin
            cnt_reg <= slow_i ? 3'h6 : 3'h1;
            drain_done_o <= 1'b0;
        end else if (prog_rd_i) begin
            drain_done_o <= 1'b0;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
            drain_done_o <= cnt_reg == 3'h1;
        end
    end
    // answers stand one cycle, then the lines show the inverse
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prog_data_o <= 32'h0000_0000;
            stk_rdata_o <= 32'h0000_0000;
        end else begin
            prog_data_o <= prog_rd_i ? {10'h000, prog_addr_i ^ VTAG} : ~prog_data_o;
            stk_rdata_o <= stk_re_i ? mem[stk_addr_i[8:1]] : ~stk_rdata_o;
        end
    end
    // stack word pairs land on even addresses, raw pointer untouched
    always_ff @(posedge clk_i) begin
        if (stk_we_i) mem[stk_addr_i[8:1]] <= wdata_i;
    end
endmodule // mis_far_model
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench for the maskable interrupt sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module tb;
    import mis_pkg::*;
    localparam logic [21:0] PC0 = 22'h01_2340;
    localparam logic [21:0] VB = 22'h00_0D00;
    localparam logic [21:0] VTAG = 22'h2A_0000;
    logic clk_i, sys_rst_i, reg_we_i, reg_re_i, dlog, os, len2, slow, drain, flush_o, pc_load_o;
    logic prog_rd_o, stk_we_o, stk_re_o, ack_o, restore_valid_o;
    logic [7:0] reg_addr_i;
    logic [13:0] gl_n;
    logic [2:0] rsel;
    logic [15:0] stk_addr_o, st1;
    logic [15:0] ctx [10];
    logic [21:0] pc_value_o, prog_addr;
    logic [31:0] reg_wdata_i, reg_rdata_o, prog_data, stk_rdata, data_write_bus_o, rdat, rd_v, ackv;
    logic [31:0] wlog [8];
    int miscompares, checks, nflush, nrest, cyc;
    mis_sequencer #(.PCW(22), .VEC_BASE(VB)) u_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata_o), .general_irq_lines_n_i(gl_n), .data_logging_irq_i(dlog),
        .os_service_irq_i(os), .pc_i(PC0), .instr_len2_i(len2), .status_zero_i(ctx[0]),
        .temp_i(ctx[1]), .acc_low_i(ctx[2]), .acc_high_i(ctx[3]), .product_low_i(ctx[4]),
        .product_high_i(ctx[5]), .aux_zero_i(ctx[6]), .aux_one_i(ctx[7]),
        .data_page_ptr_i(ctx[8]), .debug_status_word_i(ctx[9]), .drain_done_i(drain),
        .flush_o(flush_o), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
        .prog_rd_o(prog_rd_o), .prog_addr_o(prog_addr), .prog_data_i(prog_data),
        .stk_we_o(stk_we_o), .stk_re_o(stk_re_o), .stk_addr_o(stk_addr_o),
        .data_write_bus_o(data_write_bus_o), .stk_rdata_i(stk_rdata), .ack_o(ack_o),
        .restore_valid_o(restore_valid_o), .restore_sel_o(rsel), .restore_data_o(rdat),
        .status_one_o(st1)
    );
    mis_far_model #(.VTAG(VTAG)) u_far (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow), .flush_i(flush_o),
        .prog_rd_i(prog_rd_o), .stk_we_i(stk_we_o), .stk_re_i(stk_re_o),
        .prog_addr_i(prog_addr), .stk_addr_i(stk_addr_o), .wdata_i(data_write_bus_o),
        .drain_done_o(drain), .prog_data_o(prog_data), .stk_rdata_o(stk_rdata)
    );
    // clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // event counters, stack write log and hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (flush_o === 1'b1) nflush++;
        if (restore_valid_o === 1'b1) nrest++;
        if (ack_o === 1'b1) ackv = data_write_bus_o;
        if (stk_we_o === 1'b1) wlog[stk_addr_o[3:1]] = data_write_bus_o;
        if (cyc > 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // one-cycle write, then a free edge before the next strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a; reg_wdata_i <= d; reg_we_i <= 1'b1;
        @(posedge clk_i); reg_we_i <= 1'b0; @(posedge clk_i);
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        reg_addr_i <= a; reg_re_i <= 1'b1;
        @(posedge clk_i); reg_re_i <= 1'b0;
        #1 rd_v = reg_rdata_o;
        `CHK(rd_v, e)
        @(posedge clk_i);
    endtask
    task automatic wait_pc(input logic [21:0] e);
        int n;
        n = 0;
        while (pc_load_o !== 1'b1 && n < 300) begin @(posedge clk_i); #1 n++; end
        `CHK(n < 300, 1'b1)
        `CHK(pc_value_o, e)
        @(posedge clk_i);
    endtask
    initial begin
        sys_rst_i = 1'b1; reg_we_i = 1'b0; reg_re_i = 1'b0; reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0000_0000; gl_n = '1; dlog = 1'b0; os = 1'b0; len2 = 1'b0; slow = 1'b0;
        miscompares = 0; checks = 0; nflush = 0; nrest = 0; cyc = 0; ackv = 32'h0000_0000;
        for (int k = 0; k < 10; k++) ctx[k] = {4{4'(k + 1)}};
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(OFS_ENABLE, 32'h0000_0000);
        rdc(OFS_PEND_OR, 32'h0000_0000);
        // masked requests from pins, data logging, os service and software only latch
        gl_n <= 14'h3FFB; dlog <= 1'b1; os <= 1'b1;
        repeat (4) @(posedge clk_i);
        gl_n <= '1; dlog <= 1'b0; os <= 1'b0;
        wr(OFS_PEND_OR, 32'h0000_0200);
        rdc(OFS_PEND_OR, 32'h0000_C204);
        `CHK(nflush, 0)
        wr(OFS_PEND_AND, 32'h0000_0000);
        rdc(OFS_PEND_OR, 32'h0000_0000);
        $display("latch test done");
        for (int i = 0; i < 2; i++) begin
            len2 <= i[0]; slow <= i[0]; gl_n <= 14'h3FFD;
            wr(OFS_PEND_OR, 32'h0000_0004);
            wr(OFS_ENABLE, 32'h0000_0006);
            wr(OFS_STAT1, 32'h0000_00D0);
            wait_pc((VB + 22'h00_0002) ^ VTAG);
            for (int k = 0; k < 4; k++) `CHK(wlog[k], {ctx[2*k+1], ctx[2*k]})
            `CHK(wlog[4], {ctx[8], 16'h00D0})
            `CHK(wlog[5], {ctx[9], 16'h0006})
            `CHK(wlog[6], {10'h000, PC0 + 22'd1 + i[0]})
            rdc(OFS_PEND_OR, 32'h0000_0006);
            rdc(OFS_ENABLE, 32'h0000_0004);
            rdc(OFS_STAT1, 32'h0000_0003);
            rdc(OFS_SP, 32'h0000_040F);
            `CHK(nflush, i + 1)
            gl_n <= '1;
            repeat (3) @(posedge clk_i);
            wr(OFS_ENABLE, 32'h0000_0000);
            wr(OFS_PEND_AND, 32'h0000_0000);
            wr(OFS_RETURN, 32'h0000_0000);
            wait_pc(PC0 + 22'd1 + i[0]);
            rdc(OFS_SP, 32'h0000_0400);
            rdc(OFS_STAT1, 32'h0000_00D0);
            `CHK(nrest, 7 * (i + 1))
            $display("entry and return pass %0d done", i);
        end
        wr(OFS_ACK, 32'h0000_A5C3);
        @(posedge clk_i);
        `CHK(ackv, 32'h0000_A5C3)
        rdc(8'h40, 32'h0000_0000);
        $display("ack and unmapped test done");
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
